// ==== logic/lse_status_event.sv ====
// status flags, link status, event code register and interrupt line
// Notes on behaviour
// - any of three flags drives irq low
// - primary status read clears flags, irq high
// - packet flag only for clean in-sequence packet
// - packet stored first, next-expected count advances
// - connection-down bit is 1 when disconnected
// - fifteen consecutive ones set receiver idle
// - send request shows transmitter attempting to send
// - timer expiry flag set, cleared on restart
// - shift load into full fifo gives 02
// - holding register not ready aborts, gives 04
// - unready lookup segment with receive enabled gives 10
// - connection down to up gives 21
// - idle for period times retries sends disc, 22
// - sabm retries without ua sends disc, 24
// - disc/dm while up gives 30, sabm 80
// - moving to next chain segment gives 41
// - next chain segment not ready gives 42
// - supervisory command retries unacknowledged gives 88
// - received frame reject gives c0
// - sent frame reject gives c1, c3, c4, c8
// - events set error flag; software reads code
module lse_status_event #(
  parameter int TICK_CYCLES = lse_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_clk_pin,
  input wire logic rx_data_pin,
  input wire logic rx_pkt_stored,
  input wire logic rx_pkt_error,
  input wire logic [2:0] rx_pkt_seq,
  input wire logic blk_acked,
  input wire logic tx_attempting,
  input wire logic ack_timer_start,
  input wire logic ack_timer_stop,
  input wire logic rx_shift_load,
  input wire logic rx_fifo_full,
  input wire logic tx_char_need,
  input wire logic tx_holding_ready,
  input wire logic rx_seg_enter,
  input wire logic rx_buffer_ready,
  input wire logic link_up,
  input wire logic rx_disc_dm,
  input wire logic rx_sabm,
  input wire logic rx_ua,
  input wire logic rx_frmr,
  input wire logic chain_next,
  input wire logic chain_not_ready,
  input wire logic sabm_sent,
  input wire logic scmd_sent,
  input wire logic scmd_acked,
  input wire logic frmr_sent,
  input wire logic [1:0] frmr_reason,
  output logic irq_out_n,
  output logic send_disc,
  output logic tx_abort,
  output logic [2:0] next_expected_seq,
  output logic receive_enable_cmd,
  output logic ack_timer_expired
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // elaboration checks: refuse what the logic cannot serve
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  // the ones counter saturates at the threshold, so it must be reachable
  if (lse_pkg::IDLE_ONES == 4'h0) begin : g_bad_idle
    $error("IDLE_ONES must be nonzero");
  end

  // the status views below pack their fields at fixed places
  if (lse_pkg::PS_PKT_BIT != 7 || lse_pkg::PS_BLK_BIT != 6 ||
      lse_pkg::PS_ERR_BIT != 5 || lse_pkg::PS_NE_LSB != 1) begin : g_bad_primary
    $error("primary status layout differs from its view");
  end
  if (lse_pkg::LS_T1_BIT != 7 || lse_pkg::LS_SEND_BIT != 6 ||
      lse_pkg::LS_IDLE_BIT != 5 || lse_pkg::LS_DOWN_BIT != 0) begin : g_bad_link
    $error("link status layout differs from its view");
  end

  // the control bit must lie inside the data word
  if (lse_pkg::CTRL_RXEN_BIT > 31) begin : g_bad_ctrl
    $error("CTRL_RXEN_BIT outside the data word");
  end

  // event selection by severity when several arrive together
  function automatic logic [7:0] pick_code(input logic [14:0] ev,
                                           input logic [1:0] why);
    logic [7:0] c;
    c = lse_pkg::EVENT_RESET;
    if (ev[0]) c = lse_pkg::EVC_RX_OVERRUN;
    else if (ev[1]) c = lse_pkg::EVC_TX_UNDERRUN;
    else if (ev[2]) begin
      case (why)
        lse_pkg::FRMR_CTRL: c = lse_pkg::EVC_FRMR_CTRL;
        lse_pkg::FRMR_IFLD: c = lse_pkg::EVC_FRMR_IFLD;
        lse_pkg::FRMR_SIZE: c = lse_pkg::EVC_FRMR_SIZE;
        default: c = lse_pkg::EVC_FRMR_NR;
      endcase
    end
    else if (ev[3]) c = lse_pkg::EVC_FRMR_RCVD;
    else if (ev[4]) c = lse_pkg::EVC_SABM_RCVD;
    else if (ev[5]) c = lse_pkg::EVC_DISC_RCVD;
    else if (ev[6]) c = lse_pkg::EVC_IDLE_DISC;
    else if (ev[7]) c = lse_pkg::EVC_SABM_DISC;
    else if (ev[8]) c = lse_pkg::EVC_SCMD_RETRY;
    else if (ev[9]) c = lse_pkg::EVC_LOOKUP_NRDY;
    else if (ev[10]) c = lse_pkg::EVC_CHAIN_NRDY;
    else if (ev[11]) c = lse_pkg::EVC_CHAIN_NEXT;
    else if (ev[12]) c = lse_pkg::EVC_LINK_UP;
    return c;
  endfunction

  // shared retry counter step: next count and limit hit
  function automatic logic [8:0] retry_step(input logic [7:0] cnt,
                                            input logic [7:0] lim);
    logic [7:0] n;
    n = cnt + 8'h01;
    return (n >= lim) ? {1'b1, 8'h00} : {1'b0, n};
  endfunction

  // apb access decode
  wire logic acc = psel && penable;
  wire logic done = acc && pready;
  wire logic wr_done = done && pwrite;
  wire logic rd_done = done && !pwrite;
  wire logic hit_primary = paddr == lse_pkg::ADDR_PRIMARY;
  wire logic hit_link = paddr == lse_pkg::ADDR_LINK;
  wire logic hit_event = paddr == lse_pkg::ADDR_EVENT;
  wire logic hit_ctrl = paddr == lse_pkg::ADDR_CTRL;
  wire logic hit_t1 = paddr == lse_pkg::ADDR_T1;
  wire logic hit_n2 = paddr == lse_pkg::ADDR_N2;
  wire logic mapped = hit_primary || hit_link || hit_event ||
                      hit_ctrl || hit_t1 || hit_n2;

  logic pkt_q, blk_q, err_q;
  logic [7:0] event_q;
  logic [15:0] t1_q;
  logic [7:0] n2_q;
  logic idle_q, send_q, link_q, link_d1_q;
  logic [7:0] primary_view, link_view;

  assign primary_view = {pkt_q, blk_q, err_q, 1'b0, next_expected_seq, 1'b0};
  // down bit is the inverse of link_q: 0 while connected
  assign link_view = {ack_timer_expired, send_q, idle_q, 4'h0, !link_q};
  wire logic [31:0] rd_mux =
      hit_primary ? {24'h0, primary_view} :
      hit_link ? {24'h0, link_view} :
      hit_event ? {24'h0, event_q} :
      hit_ctrl ? {31'h0, receive_enable_cmd} :
      hit_t1 ? {16'h0, t1_q} :
      hit_n2 ? {24'h0, n2_q} : 32'h0;

  // one wait state so all answers come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      // error only alongside pready, in the same answer cycle
      pslverr <= acc && !pready && !mapped;
      if (acc && !pready) prdata <= pwrite ? 32'h0 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_enable_cmd <= lse_pkg::CTRL_RXEN_RESET;
      t1_q <= lse_pkg::T1_RESET;
      n2_q <= lse_pkg::N2_RESET;
    end else if (wr_done) begin
      if (hit_ctrl) receive_enable_cmd <= pwdata[lse_pkg::CTRL_RXEN_BIT];
      if (hit_t1) t1_q <= pwdata[15:0];
      if (hit_n2) n2_q <= pwdata[7:0];
    end
  end

  // serial pins: two flops each before use
  logic [1:0] rxc_s_q, rxd_s_q;
  logic rxc_last_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_s_q <= 2'b00;
      rxd_s_q <= 2'b11;
      rxc_last_q <= 1'b0;
    end else begin
      rxc_s_q <= {rxc_s_q[0], rx_clk_pin};
      rxd_s_q <= {rxd_s_q[0], rx_data_pin};
      rxc_last_q <= rxc_s_q[1];
    end
  end
  wire logic rx_bit_stb = rxc_s_q[1] && !rxc_last_q;

  // run of ones on the receive line
  logic [3:0] ones_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_q <= 4'h0;
      idle_q <= 1'b0;
    end else if (rx_bit_stb) begin
      if (!rxd_s_q[1]) begin
        ones_q <= 4'h0;
        idle_q <= 1'b0;
      end else if (ones_q != lse_pkg::IDLE_ONES) begin
        ones_q <= ones_q + 4'h1;
        idle_q <= (ones_q + 4'h1) == lse_pkg::IDLE_ONES;
      end
    end
  end

  // timer tick prescaler shared by both timers
  logic [TW-1:0] pre_q;
  wire logic tick = pre_q == TICK_LAST;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_q <= '0;
    else pre_q <= tick ? '0 : pre_q + TW'(1);
  end

  // acknowledgement timer; a zero period acts as one tick
  // start outranks stop; expiry parks the timer until the next start
  logic t1_run_q;
  logic [15:0] t1_cnt_q;
  wire logic t1_hit = tick && t1_run_q && (t1_cnt_q + 16'h1 >= t1_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_run_q <= 1'b0;
      t1_cnt_q <= 16'h0;
      ack_timer_expired <= 1'b0;
    end else if (ack_timer_start) begin
      t1_run_q <= 1'b1;
      t1_cnt_q <= 16'h0;
      ack_timer_expired <= 1'b0;
    end else if (ack_timer_stop) begin
      t1_run_q <= 1'b0;
    end else if (t1_hit) begin
      t1_run_q <= 1'b0;
      ack_timer_expired <= 1'b1;
    end else if (tick && t1_run_q) begin
      t1_cnt_q <= t1_cnt_q + 16'h1;
    end
  end

  // receiver idle watchdog over period times retries
  lse_pkg::lse_idle_state_type idle_st_q, idle_st_d;
  logic [23:0] idle_cnt_q;
  wire logic [23:0] idle_lim = t1_q * n2_q;
  wire logic idle_hit = tick && (idle_cnt_q + 24'h1 >= idle_lim);
  always_comb begin
    idle_st_d = idle_st_q;
    case (idle_st_q)
      lse_pkg::LSE_WATCH: if (idle_q) idle_st_d = lse_pkg::LSE_COUNT;
      lse_pkg::LSE_COUNT: begin
        if (!idle_q) idle_st_d = lse_pkg::LSE_WATCH;
        else if (idle_hit) idle_st_d = lse_pkg::LSE_FIRED;
      end
      lse_pkg::LSE_FIRED: if (!idle_q) idle_st_d = lse_pkg::LSE_WATCH;
      default: idle_st_d = lse_pkg::LSE_WATCH;
    endcase
  end
  // fires once per idle run; the line must break to arm it again
  wire logic idle_fire = (idle_st_q == lse_pkg::LSE_COUNT) && idle_q &&
                         idle_hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_st_q <= lse_pkg::LSE_WATCH;
      idle_cnt_q <= 24'h0;
    end else begin
      idle_st_q <= idle_st_d;
      if (idle_st_d != lse_pkg::LSE_COUNT) idle_cnt_q <= 24'h0;
      else if (tick) idle_cnt_q <= idle_cnt_q + 24'h1;
    end
  end

  // retry counts for link setup and supervisory commands
  logic [7:0] sabm_cnt_q, scmd_cnt_q;
  wire logic [8:0] sabm_nx = retry_step(sabm_cnt_q, n2_q);
  wire logic [8:0] scmd_nx = retry_step(scmd_cnt_q, n2_q);
  wire logic sabm_fire = sabm_sent && !rx_ua && sabm_nx[8];
  wire logic scmd_fire = scmd_sent && !scmd_acked && scmd_nx[8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sabm_cnt_q <= 8'h0;
      scmd_cnt_q <= 8'h0;
    end else begin
      // an acknowledgement in the same cycle as a send restarts the count
      if (rx_ua) sabm_cnt_q <= 8'h0;
      else if (sabm_sent) sabm_cnt_q <= sabm_nx[7:0];
      if (scmd_acked) scmd_cnt_q <= 8'h0;
      else if (scmd_sent) scmd_cnt_q <= scmd_nx[7:0];
    end
  end

  // event sources
  logic [14:0] ev;
  assign ev[0] = rx_shift_load && rx_fifo_full;
  assign ev[1] = tx_char_need && !tx_holding_ready;
  assign ev[2] = frmr_sent;
  assign ev[3] = rx_frmr;
  assign ev[4] = rx_sabm;
  assign ev[5] = rx_disc_dm && link_q;
  assign ev[6] = idle_fire;
  assign ev[7] = sabm_fire;
  assign ev[8] = scmd_fire;
  assign ev[9] = rx_seg_enter && !rx_buffer_ready &&
                 receive_enable_cmd;
  assign ev[10] = chain_not_ready;
  assign ev[11] = chain_next;
  assign ev[12] = link_up && !link_d1_q;
  assign ev[14:13] = 2'b00;
  wire logic any_ev = |ev;

  // clean, in-sequence, already stored packet
  wire logic pkt_ok = rx_pkt_stored && !rx_pkt_error &&
                      (rx_pkt_seq == next_expected_seq);

  // flags: a set in the clearing cycle survives
  wire logic clr = rd_done && hit_primary;
  wire logic pkt_d = pkt_ok || (pkt_q && !clr);
  wire logic blk_d = blk_acked || (blk_q && !clr);
  wire logic err_d = any_ev || (err_q && !clr);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_q <= 1'b0;
      blk_q <= 1'b0;
      err_q <= 1'b0;
      irq_out_n <= 1'b1;
      next_expected_seq <= 3'h0;
      event_q <= lse_pkg::EVENT_RESET;
    end else begin
      pkt_q <= pkt_d;
      blk_q <= blk_d;
      err_q <= err_d;
      // from the next flag values, so irq moves with the flags
      irq_out_n <= !(pkt_d || blk_d || err_d);
      if (pkt_ok) next_expected_seq <= next_expected_seq + 3'h1;
      if (any_ev) event_q <= pick_code(ev, frmr_reason);
    end
  end

  // link state, send request and action strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= 1'b0;
      link_d1_q <= 1'b0;
      send_q <= 1'b0;
      send_disc <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      link_q <= link_up;
      // previous sample of link_up; a held level reports up once
      link_d1_q <= link_up;
      send_q <= tx_attempting;
      send_disc <= idle_fire || sabm_fire;
      tx_abort <= ev[1];
    end
  end
endmodule // lse_status_event

// ==== shared/lse_pkg.sv ====
// constants, register map and types for the status and event reporter
package lse_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // register byte offsets
  localparam logic [7:0] ADDR_PRIMARY = 8'h00;
  localparam logic [7:0] ADDR_LINK = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_T1 = 8'h10;
  localparam logic [7:0] ADDR_N2 = 8'h14;
  // primary status fields
  localparam int PS_PKT_BIT = 7;
  localparam int PS_BLK_BIT = 6;
  localparam int PS_ERR_BIT = 5;
  localparam int PS_NE_LSB = 1;
  // link status fields
  localparam int LS_DOWN_BIT = 0;
  localparam int LS_IDLE_BIT = 5;
  localparam int LS_SEND_BIT = 6;
  localparam int LS_T1_BIT = 7;
  // control fields
  localparam int CTRL_RXEN_BIT = 0;
  // reset values
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic CTRL_RXEN_RESET = 1'b0;
  localparam logic [15:0] T1_RESET = 16'h000a;
  localparam logic [7:0] N2_RESET = 8'h03;
  // event codes
  localparam logic [7:0] EVC_RX_OVERRUN = 8'h02;
  localparam logic [7:0] EVC_TX_UNDERRUN = 8'h04;
  localparam logic [7:0] EVC_LOOKUP_NRDY = 8'h10;
  localparam logic [7:0] EVC_LINK_UP = 8'h21;
  localparam logic [7:0] EVC_IDLE_DISC = 8'h22;
  localparam logic [7:0] EVC_SABM_DISC = 8'h24;
  localparam logic [7:0] EVC_DISC_RCVD = 8'h30;
  localparam logic [7:0] EVC_CHAIN_NEXT = 8'h41;
  localparam logic [7:0] EVC_CHAIN_NRDY = 8'h42;
  localparam logic [7:0] EVC_SABM_RCVD = 8'h80;
  localparam logic [7:0] EVC_SCMD_RETRY = 8'h88;
  localparam logic [7:0] EVC_FRMR_RCVD = 8'hc0;
  localparam logic [7:0] EVC_FRMR_CTRL = 8'hc1;
  localparam logic [7:0] EVC_FRMR_IFLD = 8'hc3;
  localparam logic [7:0] EVC_FRMR_SIZE = 8'hc4;
  localparam logic [7:0] EVC_FRMR_NR = 8'hc8;
  // frame reject reason encoding on frmr_reason
  localparam logic [1:0] FRMR_CTRL = 2'h0;
  localparam logic [1:0] FRMR_IFLD = 2'h1;
  localparam logic [1:0] FRMR_SIZE = 2'h2;
  localparam logic [1:0] FRMR_NR = 2'h3;
  // receiver idle threshold in bits
  localparam logic [3:0] IDLE_ONES = 4'hf;
  // timer tick
  localparam int CLK_MHZ = 100;
  localparam int TIMER_TICK_US = 100;
  localparam int TICK_CYCLES = TIMER_TICK_US * CLK_MHZ;
  typedef enum logic [2:0] {
    LSE_WATCH = 3'b001,
    LSE_COUNT = 3'b010,
    LSE_FIRED = 3'b100
  } lse_idle_state_type;
endpackage

// ==== testbench/lse_remote.sv ====
// remote station model driving the serial receive pins
module lse_remote (
  output logic rx_clk_pin,
  output logic rx_data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_clk_pin = 1'b0;
    rx_data_pin = 1'b1;
  end
  // clock runs only inside a burst; line marks at one between bursts
  task automatic send(input int n, input logic [15:0] b);
    #3;
    for (int i = 0; i < n; i++) begin
      rx_data_pin = b[i];
      #40 rx_clk_pin = 1'b1;
      #40 rx_clk_pin = 1'b0;
    end
    rx_data_pin = 1'b1;
  endtask
endmodule // lse_remote

// ==== testbench/lse_status_event_sva.sv ====
// port assertions for the status and event reporter
module lse_status_event_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic rx_pkt_stored,
  input wire logic rx_pkt_error,
  input wire logic [2:0] rx_pkt_seq,
  input wire logic blk_acked,
  input wire logic ack_timer_start,
  input wire logic tx_char_need,
  input wire logic tx_holding_ready,
  input wire logic rx_seg_enter,
  input wire logic rx_buffer_ready,
  input wire logic rx_shift_load,
  input wire logic rx_fifo_full,
  input wire logic rx_sabm,
  input wire logic chain_next,
  input wire logic rx_frmr,
  input wire logic irq_out_n,
  input wire logic tx_abort,
  input wire logic [2:0] next_expected_seq,
  input wire logic receive_enable_cmd,
  input wire logic ack_timer_expired
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic rd_pri = psel && penable && pready && !pwrite && paddr == lse_pkg::ADDR_PRIMARY;
  wire logic pkt_ok = rx_pkt_stored && !rx_pkt_error && rx_pkt_seq == next_expected_seq;
  property p_irq_flag;
    blk_acked |=> !irq_out_n;
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq high after ack");
  // one extra cycle allowed for the registered irq
  property p_rd_clear;
    rd_pri |-> ##[1:2] irq_out_n;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("irq stuck low");
  property p_pkt_skip;
    rx_pkt_stored && !pkt_ok |=> $stable(next_expected_seq);
  endproperty
  a_pkt_skip: assert property (p_pkt_skip) else $error("count moved on bad packet");
  property p_pkt_adv;
    pkt_ok |=> next_expected_seq == $past(next_expected_seq) + 3'h1;
  endproperty
  a_pkt_adv: assert property (p_pkt_adv) else $error("count not advanced");
  property p_seq_hold;
    !rx_pkt_stored |=> $stable(next_expected_seq);
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("count moved idle");
  property p_t1_restart;
    ack_timer_start |=> !ack_timer_expired;
  endproperty
  a_t1_restart: assert property (p_t1_restart) else $error("expiry kept on start");
  property p_underrun;
    tx_char_need && !tx_holding_ready |-> ##[1:2] tx_abort;
  endproperty
  a_underrun: assert property (p_underrun) else $error("no abort");
  property p_lookup;
    rx_seg_enter && !rx_buffer_ready && receive_enable_cmd |=> !irq_out_n;
  endproperty
  a_lookup: assert property (p_lookup) else $error("no lookup event");
  property p_event_irq;
    rx_frmr || rx_sabm || chain_next || rx_shift_load && rx_fifo_full |=> !irq_out_n;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("no event irq");
endmodule // lse_status_event_sva

bind lse_status_event lse_status_event_sva u_lse_status_event_sva (.*);

// ==== testbench/tb.sv ====
// self-checking bench for the status and event reporter
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, er, irq_out_n, send_disc, tx_abort, receive_enable_cmd;
  logic ack_timer_expired, rx_clk_pin, rx_data_pin, x, ok;
  logic [2:0] next_expected_seq, s;
  logic rx_fifo_full = 1'b1;
  logic tx_holding_ready = 1'b0;
  logic rx_buffer_ready = 1'b0;
  logic rx_pkt_error = 1'b0;
  logic link_up = 1'b0;
  logic tx_attempting = 1'b1;
  logic [2:0] rx_pkt_seq = 3'h0;
  logic [1:0] frmr_reason = 2'h0;
  logic [16:0] pv = 17'h0;
  logic rx_shift_load, tx_char_need, rx_seg_enter, rx_disc_dm, rx_sabm, chain_next;
  logic chain_not_ready, rx_frmr, frmr_sent, sabm_sent, scmd_sent, rx_pkt_stored;
  logic blk_acked, ack_timer_start, ack_timer_stop, rx_ua, scmd_acked;
  logic [7:0] rnd = 8'h40;
  int num_errors = 0;
  int cmp_count = 0;
  int ne = 0;
  int nd = 0;
  int na = 0;
  int ecode = 0;
  int tk[6] = '{0, 1, 4, 5, 6, 7};
  int tc[6] = '{'h02, 'h04, 'h80, 'h41, 'h42, 'hc0};
  int fc[4] = '{'hc1, 'hc3, 'hc4, 'hc8};
  assign {scmd_acked, rx_ua, ack_timer_stop, ack_timer_start, blk_acked, rx_pkt_stored,
    scmd_sent, sabm_sent, frmr_sent, rx_frmr, chain_not_ready, chain_next, rx_sabm,
    rx_disc_dm, rx_seg_enter, tx_char_need, rx_shift_load} = pv;
  initial forever #5 pclk = ~pclk;
  lse_remote u_lse_remote (.rx_clk_pin, .rx_data_pin);
  // short tick keeps timer scenarios to a few hundred cycles
  lse_status_event #(.TICK_CYCLES(4)) u_lse_status_event (.*);
  always @(posedge pclk) begin
    nd <= nd + int'(send_disc === 1'b1);
    na <= na + int'(tx_abort === 1'b1);
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task pulse(input int k);
    @(posedge pclk);
    pv <= 17'h1 << k;
    @(posedge pclk);
    pv <= 17'h0;
  endtask
  task ev(input int k, input int c);
    if (k >= 0) pulse(k);
    else @(posedge pclk);
    #1 chk(irq_out_n, 1'b0);
    ecode = c;
    rd(lse_pkg::ADDR_EVENT, ecode);
    rd(lse_pkg::ADDR_PRIMARY, 32'h20 | (ne << 1));
    rd(lse_pkg::ADDR_EVENT, ecode);
    repeat (2) @(posedge pclk);
    #1 chk(irq_out_n, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(lse_pkg::ADDR_PRIMARY, 32'h0);
    rd(lse_pkg::ADDR_LINK, 32'h41);
    rd(lse_pkg::ADDR_EVENT, lse_pkg::EVENT_RESET);
    rd(lse_pkg::ADDR_T1, lse_pkg::T1_RESET);
    rd(lse_pkg::ADDR_N2, lse_pkg::N2_RESET);
    apb(1'b1, lse_pkg::ADDR_T1, 32'h5);
    rd(lse_pkg::ADDR_T1, 32'h5);
    apb(1'b1, lse_pkg::ADDR_T1, {16'h0, lse_pkg::T1_RESET});
    apb(1'b1, lse_pkg::ADDR_LINK, 32'hff);
    rd(lse_pkg::ADDR_LINK, 32'h41);
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], er}, 32'h1);
    // receive disabled: unready segment must stay silent
    pulse(2);
    #1 chk(irq_out_n, 1'b1);
    apb(1'b1, lse_pkg::ADDR_CTRL, 32'h1);
    #1 chk(receive_enable_cmd, 1'b1);
    ev(2, 'h10);
    foreach (tk[i]) ev(tk[i], tc[i]);
    // qualifiers true: the same strobes must stay silent
    rx_fifo_full <= 1'b0;
    tx_holding_ready <= 1'b1;
    rx_buffer_ready <= 1'b1;
    for (int k = 0; k < 3; k++) pulse(k);
    repeat (2) @(posedge pclk);
    #1 chk(irq_out_n, 1'b1);
    chk(na, 1);
    for (int r = 0; r < 4; r++) begin
      frmr_reason <= 2'(r);
      ev(8, fc[r]);
    end
    @(posedge pclk);
    link_up <= 1'b1;
    tx_attempting <= 1'b0;
    ev(-1, 'h21);
    rd(lse_pkg::ADDR_LINK, 32'h0);
    ev(3, 'h30);
    // acknowledge in between restarts the retry count
    pulse(9);
    pulse(15);
    pulse(9);
    pulse(9);
    #1 chk(irq_out_n, 1'b1);
    ev(9, 'h24);
    chk(nd, 1);
    pulse(10);
    pulse(10);
    ev(10, 'h88);
    pulse(12);
    #1 chk(irq_out_n, 1'b0);
    rd(lse_pkg::ADDR_PRIMARY, 32'h40 | (ne << 1));
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      s = (i == 4) ? 3'(ne + 1) : (rnd[0] ? 3'(ne) : rnd[3:1]);
      x = (i == 2);
      rx_pkt_seq <= s;
      rx_pkt_error <= x;
      pulse(11);
      ok = !x && s == 3'(ne);
      if (ok) ne = (ne + 1) % 8;
      #1 chk(irq_out_n, !ok);
      chk(next_expected_seq, ne);
      rd(lse_pkg::ADDR_PRIMARY, (ok ? 32'h80 : 32'h0) | (ne << 1));
    end
    pulse(13);
    repeat (30) @(posedge pclk);
    #1 chk(ack_timer_expired, 1'b0);
    for (int i = 0; i < 20 && ack_timer_expired !== 1'b1; i++) @(posedge pclk);
    #1 chk(ack_timer_expired, 1'b1);
    rd(lse_pkg::ADDR_LINK, 32'h80);
    pulse(13);
    #1 chk(ack_timer_expired, 1'b0);
    pulse(14);
    // a zero then fourteen ones is one short of idle
    u_lse_remote.send(15, 16'h7ffe);
    repeat (10) @(posedge pclk);
    rd(lse_pkg::ADDR_LINK, 32'h0);
    u_lse_remote.send(1, 16'h1);
    repeat (10) @(posedge pclk);
    rd(lse_pkg::ADDR_LINK, 32'h20);
    for (int i = 0; i < 300 && nd < 2; i++) @(posedge pclk);
    chk(nd, 2);
    ecode = 'h22;
    rd(lse_pkg::ADDR_EVENT, ecode);
    stop_test();
  end
endmodule // tb
